//--- core/tx_part_pkg.sv
// constants for the transmit partition write port
package tx_part_pkg;
    localparam int WORD_W       = 64;
    localparam int BE_W         = 8;
    localparam int SEL_W        = 3;
    localparam int MAX_PARTS    = 8;
    localparam int HALVES       = 2;
    localparam int LINE_W       = WORD_W * HALVES;
    localparam int DEPTH_32     = 16;
    localparam int DEPTH_MUL_64 = 2;
    localparam int DEPTH_64     = DEPTH_32 * DEPTH_MUL_64;
    localparam logic [BE_W-1:0] BE_NONE = 8'h00;
    localparam logic HALF_LOW   = 1'b0;
    localparam logic HALF_HIGH  = 1'b1;

    typedef enum logic [1:0] {
        ARB_POLL = 2'b00,
        ARB_SEND = 2'b01
    } arb_state_t;
endpackage

//--- core/spi4_tx_partition_write_port.sv
// transmit buffer write port with virtual partitions and egress polling
//
// Notes on behaviour
// - a high link disable stops the egress arbiter polling this buffer.
// - partitions of a disabled buffer get no service until it is released.
// - while disabled the egress side presents idle words once any line already offered is taken.
// - writes to a disabled buffer are still stored until the partition fills.
// - the write side runs on its own write clock, here the block clock.
// - the full flag reports the partition picked by the 3-bit select.
// - the full flag rises once occupancy reaches the fill threshold.
// - the buffer holds up to eight partitions picked by the 3-bit select.
// - each partition holds twice the 32-bit mode depth in 64-bit mode.
// - many link ports may write into one shared partition.
// - a write strobe with a nonzero byte enable to a valid, non-full partition captures the 64-bit write word.
// - line terminate moves the selected partition to its next line only when its line is half filled.
`timescale 1ns/100ps
module spi4_tx_partition_write_port
    import tx_part_pkg::*;
#(
    parameter int NUM_PARTS  = tx_part_pkg::MAX_PARTS,
    parameter int PART_DEPTH = tx_part_pkg::DEPTH_64
) (
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    input  wire logic                          write_strobe,
    input  wire logic [tx_part_pkg::WORD_W-1:0] write_word,
    input  wire logic [tx_part_pkg::BE_W-1:0]  byte_enable,
    input  wire logic                          packet_start_flag,
    input  wire logic                          packet_end_flag,
    input  wire logic                          packet_error_flag,
    input  wire logic [7:0]                    link_port,
    input  wire logic [tx_part_pkg::SEL_W-1:0] virtual_fifo_select,
    input  wire logic                          line_terminate,
    input  wire logic                          tx_buffer_link_disable,
    input  wire logic [$clog2(PART_DEPTH):0]   fill_threshold,
    output logic                               partition_full_flag,
    input  wire logic                          egress_ready,
    output logic                               egress_valid,
    output logic                               egress_idle,
    output logic [tx_part_pkg::LINE_W-1:0]     egress_line,
    output logic [tx_part_pkg::SEL_W-1:0]      egress_partition,
    output logic [7:0]                         egress_port,
    output logic                               egress_sop,
    output logic                               egress_eop,
    output logic                               egress_err,
    output logic                               egress_half_only
);
    import tx_part_pkg::*;

    localparam int PTR_W = $clog2(PART_DEPTH);
    localparam int OCC_W = PTR_W + 1;
    localparam int ENTRIES = NUM_PARTS * PART_DEPTH;
    localparam int ADDR_W = $clog2(ENTRIES);

    // refuse shapes the pointer and address arithmetic cannot serve
    if (NUM_PARTS < 1 || NUM_PARTS > MAX_PARTS) begin : g_bad_parts
        $error("partition count out of range");
    end
    if (PART_DEPTH < 2
        || (PART_DEPTH & (PART_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("partition depth must be a power of two");
    end

    ////////////////////////////////////////////////////////////////////////
    // storage, one entry per 128-bit line
    logic [LINE_W-1:0] line_mem [ENTRIES];
    logic [7:0]        port_mem [ENTRIES];
    logic              sop_mem  [ENTRIES];
    logic              eop_mem  [ENTRIES];
    logic              err_mem  [ENTRIES];
    logic              half_mem [ENTRIES];

    logic [PTR_W-1:0] wptr_q [NUM_PARTS];
    logic [PTR_W-1:0] rptr_q [NUM_PARTS];
    logic [OCC_W-1:0] occ_q  [NUM_PARTS];
    logic             half_q [NUM_PARTS];

    function automatic logic [ADDR_W-1:0] entry_addr(
        input logic [SEL_W-1:0] part,
        input logic [PTR_W-1:0] ptr
    );
        logic [31:0] flat;
        flat = 32'(part) * 32'(PART_DEPTH) + 32'(ptr);
        return flat[ADDR_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write side
    logic              sel_ok;
    logic              sel_full;
    logic              wr_take;
    logic              wr_commit;
    logic              lt_commit;
    logic [ADDR_W-1:0] wr_addr;

    // select values past the configured count are ignored
    assign sel_ok   = 32'(virtual_fifo_select) < 32'(NUM_PARTS);
    assign sel_full = occ_q[virtual_fifo_select] == OCC_W'(PART_DEPTH);
    // storing does not look at link disable, so a stalled buffer still fills
    assign wr_take  = write_strobe && sel_ok && !sel_full
                    && byte_enable != BE_NONE;
    assign wr_commit = wr_take && (half_q[virtual_fifo_select] == HALF_HIGH
                    || packet_end_flag);
    // terminate closes a started line; an empty line is not sent
    assign lt_commit = line_terminate && sel_ok && !sel_full
                    && !wr_take
                    && half_q[virtual_fifo_select] == HALF_HIGH;
    assign wr_addr = entry_addr(virtual_fifo_select,
                                wptr_q[virtual_fifo_select]);

    always_ff @(posedge sys_clk) begin
        if (wr_take) begin
            if (half_q[virtual_fifo_select] == HALF_LOW) begin
                line_mem[wr_addr][WORD_W-1:0] <= write_word;
                sop_mem[wr_addr]  <= packet_start_flag;
                port_mem[wr_addr] <= link_port;
                half_mem[wr_addr] <= 1'b1;
            end else begin
                line_mem[wr_addr][LINE_W-1:WORD_W] <= write_word;
                half_mem[wr_addr] <= 1'b0;
            end
            eop_mem[wr_addr] <= packet_end_flag;
            // error is stored only when it arrives with the end flag
            err_mem[wr_addr] <= packet_error_flag && packet_end_flag;
        end else if (lt_commit) begin
            eop_mem[wr_addr] <= 1'b0;
            err_mem[wr_addr] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // egress polling arbiter
    arb_state_t       state_q;
    logic [SEL_W-1:0] last_q;
    logic [SEL_W-1:0] pick;
    logic             pick_ok;
    logic             rd_take;

    always_comb begin
        logic [SEL_W-1:0] cand;
        cand = last_q;
        pick = last_q;
        pick_ok = 1'b0;
        for (int i = 1; i <= MAX_PARTS; i++) begin
            cand = SEL_W'(32'(last_q) + i);
            if (!pick_ok && 32'(cand) < 32'(NUM_PARTS)
                && occ_q[cand] != '0) begin
                pick = cand;
                pick_ok = 1'b1;
            end
        end
    end

    // a disabled buffer is never polled, whatever it holds
    assign rd_take = state_q == ARB_POLL && pick_ok
                   && !tx_buffer_link_disable;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ARB_POLL;
            last_q  <= '0;
        end else begin
            case (state_q)
                ARB_POLL: begin
                    if (rd_take) begin
                        state_q <= ARB_SEND;
                        last_q  <= pick;
                    end
                end
                ARB_SEND: begin
                    if (egress_ready)
                        state_q <= ARB_POLL;
                end
                default: state_q <= ARB_POLL;
            endcase
        end
    end

    logic [ADDR_W-1:0] rd_addr;
    assign rd_addr = entry_addr(pick, rptr_q[pick]);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            egress_line      <= '0;
            egress_partition <= '0;
            egress_port      <= '0;
            egress_sop       <= 1'b0;
            egress_eop       <= 1'b0;
            egress_err       <= 1'b0;
            egress_half_only <= 1'b0;
        end else if (rd_take) begin
            egress_line      <= line_mem[rd_addr];
            egress_partition <= pick;
            egress_port      <= port_mem[rd_addr];
            egress_sop       <= sop_mem[rd_addr];
            egress_eop       <= eop_mem[rd_addr];
            egress_err       <= err_mem[rd_addr];
            egress_half_only <= half_mem[rd_addr];
        end
    end

    assign egress_valid = state_q == ARB_SEND;
    // idle control words go out whenever no line is offered
    assign egress_idle  = state_q != ARB_SEND;

    ////////////////////////////////////////////////////////////////////////
    // per-partition pointers and occupancy
    for (genvar p = 0; p < NUM_PARTS; p++) begin : g_part
        logic hit_w;
        logic hit_r;
        assign hit_w = (wr_commit || lt_commit)
                     && virtual_fifo_select == SEL_W'(p);
        assign hit_r = rd_take && pick == SEL_W'(p);

        always_ff @(posedge sys_clk) begin
            if (srst) begin
                wptr_q[p] <= '0;
                rptr_q[p] <= '0;
                half_q[p] <= HALF_LOW;
                occ_q[p]  <= '0;
            end else begin
                if (hit_w) begin
                    wptr_q[p] <= wptr_q[p] + PTR_W'(1);
                    half_q[p] <= HALF_LOW;
                end else if (wr_take && virtual_fifo_select == SEL_W'(p))
                    half_q[p] <= HALF_HIGH;
                if (hit_r)
                    rptr_q[p] <= rptr_q[p] + PTR_W'(1);
                // depth per partition is the doubled 64-bit figure
                if (hit_w && !hit_r)
                    occ_q[p] <= occ_q[p] + OCC_W'(1);
                else if (hit_r && !hit_w)
                    occ_q[p] <= occ_q[p] - OCC_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // full flag, registered on the write clock
    always_ff @(posedge sys_clk) begin
        if (srst)
            partition_full_flag <= 1'b0;
        else
            partition_full_flag <= sel_ok
                && (occ_q[virtual_fifo_select] >= fill_threshold
                    || sel_full);
    end
endmodule

//--- test/tx_part_properties.sv
// assertions on the ports of the transmit partition write port
`timescale 1ns/100ps
module tx_part_properties #(
    parameter int NUM_PARTS  = 8,
    parameter int PART_DEPTH = 32
) (
    input wire logic                        sys_clk,
    input wire logic                        srst,
    input wire logic                        write_strobe,
    input wire logic                        line_terminate,
    input wire logic [2:0]                  virtual_fifo_select,
    input wire logic [$clog2(PART_DEPTH):0] fill_threshold,
    input wire logic                        tx_buffer_link_disable,
    input wire logic                        partition_full_flag,
    input wire logic                        egress_ready,
    input wire logic                        egress_valid,
    input wire logic                        egress_idle,
    input wire logic [127:0]                egress_line,
    input wire logic [2:0]                  egress_partition,
    input wire logic                        egress_eop,
    input wire logic                        egress_err
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    property p_no_poll;
        tx_buffer_link_disable && !egress_valid |=> !egress_valid;
    endproperty
    a_no_poll: assert property (p_no_poll) else $error("polled");
    property p_idle;
        egress_idle != egress_valid;
    endproperty
    a_idle: assert property (p_idle) else $error("idle wrong");
    property p_hold;
        egress_valid && !egress_ready |=>
            egress_valid && $stable(egress_line) && $stable(egress_partition);
    endproperty
    a_hold: assert property (p_hold) else $error("line dropped");
    property p_gap;
        egress_valid && egress_ready |=> !egress_valid;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle gap");
    property p_rst;
        $fell(srst) |-> !partition_full_flag && egress_idle;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_err;
        egress_valid && egress_err |-> egress_eop;
    endproperty
    a_err: assert property (p_err) else $error("error sans end");
    property p_part;
        egress_valid |-> egress_partition < NUM_PARTS;
    endproperty
    a_part: assert property (p_part) else $error("bad partition");
    // held off only while nothing can move occupancy or selection
    property p_quiet;
        (tx_buffer_link_disable && !egress_valid && !write_strobe
         && !line_terminate && $stable(virtual_fifo_select)
         && $stable(fill_threshold))[*4] |-> $stable(partition_full_flag);
    endproperty
    a_quiet: assert property (p_quiet) else $error("flag moved");
endmodule
bind spi4_tx_partition_write_port tx_part_properties #(
    .NUM_PARTS(NUM_PARTS), .PART_DEPTH(PART_DEPTH)) chk_u (.sys_clk,
    .srst, .write_strobe, .line_terminate, .virtual_fifo_select,
    .fill_threshold, .tx_buffer_link_disable, .partition_full_flag,
    .egress_ready, .egress_valid, .egress_idle, .egress_line,
    .egress_partition, .egress_eop, .egress_err);

//--- test/tx_writer_model.sv
// fabric writer model driving the write side of the port
`timescale 1ns/100ps
module tx_writer_model (
    input  wire logic   sys_clk,
    output logic        write_strobe,
    output logic [63:0] write_word,
    output logic [7:0]  byte_enable,
    output logic        packet_start_flag,
    output logic        packet_end_flag,
    output logic        packet_error_flag,
    output logic [7:0]  link_port,
    output logic [2:0]  virtual_fifo_select,
    output logic        line_terminate
);
    initial begin
        {write_strobe, packet_start_flag, packet_end_flag} = 3'h0;
        {packet_error_flag, line_terminate} = 2'h0;
        write_word = 64'h0;
        byte_enable = 8'h00;
        link_port = 8'h00;
        virtual_fifo_select = 3'h0;
    end
    task automatic wr(input logic [2:0] s, input logic [63:0] w,
                      input logic so, input logic eo, input logic er);
        @(posedge sys_clk);
        write_strobe <= 1'b1;
        write_word <= w;
        byte_enable <= 8'hff;
        packet_start_flag <= so;
        packet_end_flag <= eo;
        packet_error_flag <= er & eo;
        // port number kept apart from the select so a swap shows
        link_port <= {5'h15, s};
        virtual_fifo_select <= s;
        @(posedge sys_clk);
        write_strobe <= 1'b0;
        // a released word bus must not look like the last word
        write_word <= ~w;
    endtask
    task automatic line2(input logic [2:0] s, input logic [63:0] a, b,
                         input logic so, input logic eo, input logic er);
        wr(s, a, so, 1'b0, 1'b0);
        wr(s, b, 1'b0, eo, er);
    endtask
    task automatic term(input logic [2:0] s);
        @(posedge sys_clk);
        line_terminate <= 1'b1;
        virtual_fifo_select <= s;
        @(posedge sys_clk);
        line_terminate <= 1'b0;
    endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the transmit partition write port
`timescale 1ns/100ps
module testbench;
    logic         sys_clk, srst, tx_buffer_link_disable, egress_ready;
    logic         write_strobe, packet_start_flag, packet_end_flag;
    logic         packet_error_flag, line_terminate, partition_full_flag;
    logic         egress_valid, egress_idle, egress_sop, egress_eop;
    logic         egress_err, egress_half_only;
    logic [63:0]  write_word;
    logic [7:0]   byte_enable, link_port, egress_port;
    logic [2:0]   virtual_fifo_select, egress_partition;
    logic [5:0]   fill_threshold;
    logic [127:0] egress_line;
    int           fails, checks;
    spi4_tx_partition_write_port dut_u (.sys_clk, .srst, .write_strobe,
        .write_word, .byte_enable, .packet_start_flag, .packet_end_flag,
        .packet_error_flag, .link_port, .virtual_fifo_select,
        .line_terminate, .tx_buffer_link_disable, .fill_threshold,
        .partition_full_flag, .egress_ready, .egress_valid, .egress_idle,
        .egress_line, .egress_partition, .egress_port, .egress_sop,
        .egress_eop, .egress_err, .egress_half_only);
    tx_writer_model wr_u (.sys_clk, .write_strobe, .write_word,
        .byte_enable, .packet_start_flag, .packet_end_flag,
        .packet_error_flag, .link_port, .virtual_fifo_select,
        .line_terminate);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [127:0] e, g);
        checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    task automatic complete_run;
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // bounded wait for an offered line, looked at mid-cycle
    task automatic take;
        for (int n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            if (egress_valid === 1'b1)
                return;
        end
        fails++;
        complete_run();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        checks = 0;
        srst = 1'b1;
        tx_buffer_link_disable = 1'b1;
        egress_ready = 1'b0;
        fill_threshold = 6'h02;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        chk("full", 1'b0, partition_full_flag);
        wr_u.line2(3'h3, 64'h11, 64'h22, 1'b1, 1'b0, 1'b0);
        wr_u.line2(3'h3, 64'h33, 64'h44, 1'b0, 1'b1, 1'b1);
        repeat (6) @(negedge sys_clk);
        chk("full", 1'b1, partition_full_flag);
        chk("idle", 1'b1, egress_idle);
        wr_u.term(3'h5);
        repeat (4) @(negedge sys_clk);
        chk("full sel5", 1'b0, partition_full_flag);
        @(posedge sys_clk);
        tx_buffer_link_disable <= 1'b0;
        take();
        chk("line1", {64'h22, 64'h11}, egress_line);
        chk("part1", 3'h3, egress_partition);
        chk("sop", 1'b1, egress_sop);
        chk("port", 8'hab, egress_port);
        @(posedge sys_clk);
        egress_ready <= 1'b1;
        @(posedge sys_clk);
        take();
        chk("line2", {64'h44, 64'h33}, egress_line);
        chk("eop err", 2'h3, {egress_eop, egress_err});
        wr_u.term(3'h3);
        repeat (4) @(negedge sys_clk);
        chk("full drained", 1'b0, partition_full_flag);
        wr_u.wr(3'h5, 64'h55, 1'b1, 1'b1, 1'b0);
        take();
        chk("half eop", {1'b1, 64'h55},
            {egress_half_only, egress_line[63:0]});
        wr_u.wr(3'h0, 64'h66, 1'b1, 1'b0, 1'b0);
        wr_u.term(3'h0);
        take();
        chk("term", {4'h8, 64'h66}, {egress_half_only, egress_partition,
            egress_line[63:0]});
        // fill one partition to its doubled depth with egress stalled
        @(posedge sys_clk);
        tx_buffer_link_disable <= 1'b1;
        fill_threshold <= 6'h20;
        for (int i = 0; i < 32; i++) begin
            wr_u.wr(3'h6, 64'h100 + 64'(i), 1'b1, 1'b1, 1'b0);
            if (i == 30) begin
                repeat (2) @(negedge sys_clk);
                chk("full 31", 1'b0, partition_full_flag);
            end
        end
        repeat (2) @(negedge sys_clk);
        chk("full 32", 1'b1, partition_full_flag);
        wr_u.wr(3'h6, 64'hdead, 1'b1, 1'b1, 1'b0);
        @(posedge sys_clk);
        tx_buffer_link_disable <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            take();
            chk("fill line", 64'h100 + 64'(i), egress_line[63:0]);
        end
        repeat (4) @(negedge sys_clk);
        chk("overflow", 1'b0, egress_valid);
        complete_run();
    end
endmodule
